/* File: hdl/tcop_pkg.sv */
// Purpose: Shared constants and carriers for the trace-cache pipeline.
// Assumes: Word-addressed instruction stream, one uop per instruction.
// Notes: All timing is counted in core cycles.
package tcop_pkg;
	// ****************************************************************
	// Sizes and limits
	// ****************************************************************
	localparam int AW = 16;
	localparam int ROB_DEPTH = 8;
	localparam int TC_ENTRIES = 8;
	localparam int BPRED_ENTRIES = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int MAX_DISPATCH = 6;
	localparam int MAX_RETIRE = 3;
	localparam int ALU_PORTS = 2;
	localparam logic [3:0] FP_LAT = 4'h1;
	localparam logic [AW-1:0] RESET_PC = 16'h0000;
	localparam logic [AW-1:0] EXC_VECTOR = 16'h0100;

	// ****************************************************************
	// Uop kinds, carrier and front-end states
	// ****************************************************************
	localparam logic [1:0] KIND_ALU = 2'h0;
	localparam logic [1:0] KIND_FP = 2'h1;
	localparam logic [1:0] KIND_MEM = 2'h2;
	localparam logic [1:0] KIND_BR = 2'h3;

	typedef struct packed {
		logic [AW-1:0] pc;
		logic [1:0] kind;
		logic [3:0] lat;
		logic store;
		logic exc;
		logic [AW-1:0] tgt;
		logic [AW-1:0] pred;
	} tcop_uop_type;

	typedef enum logic [2:0] {
		FE_IDLE = 3'h1,
		FE_WAIT = 3'h2,
		FE_TRACE = 3'h4
	} tcop_fe_type;
endpackage : tcop_pkg

/* File: hdl/tcop_core.sv */
// Purpose: Trace-cache front end, out-of-order issue and in-order retire.
// Assumes: Memory answers one fetch at a time with mem_valid.
// Notes: Every output is registered; one clock domain throughout.
// Functional notes
// - Front end hands uops to the core in program order.
// - Basic integer ops complete within one core cycle.
// - Decoded memory instructions are written into the trace cache.
// - Predicted branch target uops directly follow the branch.
// - A trace cache hit stops memory fetch and becomes the source.
// - Branch targets are predicted from the branch address in the buffer.
// - Targets come from the trace cache if present, else memory.
// - Traces are built along the predicted path.
// - Stalled uops let younger ready uops execute around them.
// - At most six uops dispatch per cycle.
// - ALU, memory and branch pipelines accept a new uop every cycle.
// - Two ALU starts per cycle; one FP start every two cycles.
// - A uop issues once operands are ready and a unit is free.
// - Retirement updates state strictly in program order.
// - Stores commit in order, one at a time, total store order.
// - Exceptions are raised only at the oldest uop, then restart.
// - At most three uops retire per cycle.
// - Reorder buffer holds completed uops and orders exceptions.
// - Retired branches update the branch target buffer.
// - Stale traces are purged and new paths fetched.
`timescale 1ns/1ns

// ********************************************************************
// Uop queue between front end and core
// ********************************************************************
module tcop_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AB = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [AB-1:0] rd_q;
	logic [AB-1:0] wr_q;
	logic [AB:0] cnt_q;
	logic push;
	logic pop;

	if (D < 2 || D != (1 << AB)) begin : g_bad
		$error("tcop_fifo: depth must be a power of two");
	end

	// Honest flags; the front end stalls on in_ready.
	assign in_ready = cnt_q != (AB+1)'(D);
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointers; a flush drops wrong-path uops.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rd_q <= '0;
			wr_q <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			rd_q <= '0;
			wr_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + (AB+1)'(push) - (AB+1)'(pop);
		end
	end

	// Storage needs no reset.
	always_ff @(posedge clk_sys) begin
		if (push)
			mem_q[wr_q] <= in_data;
	end
endmodule : tcop_fifo

// ********************************************************************
// Pipeline control
// ********************************************************************
module tcop_core #(
	parameter int ROB_DEPTH = tcop_pkg::ROB_DEPTH,
	parameter int TC_ENTRIES = tcop_pkg::TC_ENTRIES,
	parameter int BPRED_ENTRIES = tcop_pkg::BPRED_ENTRIES
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic mem_valid,
	input wire tcop_pkg::tcop_uop_type mem_uop,
	output logic fetch_req,
	output logic [tcop_pkg::AW-1:0] fetch_addr,
	output logic trace_source,
	output logic [1:0] retire_count,
	output logic store_valid,
	output logic [tcop_pkg::AW-1:0] store_addr,
	output logic exc_valid,
	output logic [tcop_pkg::AW-1:0] exc_pc,
	output logic redirect
);
	import tcop_pkg::*;
	localparam int RB = $clog2(ROB_DEPTH);
	localparam int TB = $clog2(TC_ENTRIES);
	localparam int BB = $clog2(BPRED_ENTRIES);

	if (ROB_DEPTH != (1 << RB) || ROB_DEPTH < MAX_RETIRE || TC_ENTRIES != (1 << TB)
			|| BPRED_ENTRIES != (1 << BB)) begin : g_bad
		$error("tcop_core: table sizes must be powers of two");
	end

	tcop_fe_type fe_q;
	logic [AW-1:0] pc_q;
	logic drop_q;
	logic fetch_req_q;
	logic [AW-1:0] fetch_addr_q;
	tcop_uop_type tc_uop_q [TC_ENTRIES];
	logic [TC_ENTRIES-1:0] tc_v_q;
	logic [AW-1:0] bpred_tag_q [BPRED_ENTRIES];
	logic [AW-1:0] bpred_tgt_q [BPRED_ENTRIES];
	logic [BPRED_ENTRIES-1:0] bpred_v_q;
	tcop_uop_type rob_uop_q [ROB_DEPTH];
	logic [ROB_DEPTH-1:0] rob_v_q;
	logic [ROB_DEPTH-1:0] rob_iss_q;
	logic [ROB_DEPTH-1:0] rob_done_q;
	logic [3:0] rob_wait_q [ROB_DEPTH];
	logic [RB-1:0] head_q;
	logic [RB-1:0] tail_q;
	logic [RB:0] cnt_q;
	logic fp_busy_q;
	logic [1:0] retire_count_q;
	logic store_valid_q;
	logic [AW-1:0] store_addr_q;
	logic exc_valid_q;
	logic [AW-1:0] exc_pc_q;
	logic redirect_q;
	logic tc_hit;
	logic bpred_hit;
	logic fe_push;
	logic flush;
	logic mis_d;
	logic [AW-1:0] purge_pc;
	logic q_in_ready;
	logic q_valid;
	logic q_pop;
	tcop_uop_type fe_uop;
	tcop_uop_type q_uop;
	logic [AW-1:0] fe_next;
	logic [AW-1:0] redir_pc;
	logic [TB-1:0] tc_idx;
	logic [BB-1:0] bpred_idx;
	logic [BB-1:0] upd_idx;

	// Both tables are direct mapped on the low address bits.
	assign tc_idx = pc_q[TB-1:0];
	assign bpred_idx = pc_q[BB-1:0];

	// ****************************************************************
	// Front end: trace cache, branch prediction and fetch
	// ****************************************************************
	assign tc_hit = tc_v_q[tc_idx] && tc_uop_q[tc_idx].pc == pc_q;
	assign bpred_hit = bpred_v_q[bpred_idx] && bpred_tag_q[bpred_idx] == pc_q;

	// Source pick and next address; the target follows its branch directly.
	always_comb begin
		fe_uop = (fe_q == FE_WAIT) ? mem_uop : tc_uop_q[tc_idx];
		fe_uop.pc = pc_q;
		if (fe_uop.kind == KIND_BR && bpred_hit)
			fe_next = bpred_tgt_q[bpred_idx];
		else
			fe_next = pc_q + 1'b1;
		fe_uop.pred = fe_next;
	end

	// A late answer to a flushed fetch is dropped, never queued.
	assign fe_push = !flush && ((fe_q != FE_WAIT && q_in_ready && tc_hit)
		|| (fe_q == FE_WAIT && mem_valid && !drop_q));

	// Fetch sequencing; memory is asked only when the trace cache misses.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fe_q <= FE_IDLE;
			pc_q <= RESET_PC;
			drop_q <= 1'b0;
			fetch_req_q <= 1'b0;
			fetch_addr_q <= RESET_PC;
		end else begin
			case (fe_q)
				FE_WAIT: begin
					if (mem_valid) begin
						fetch_req_q <= 1'b0;
						drop_q <= 1'b0;
						fe_q <= FE_IDLE;
					end else if (flush) begin
						drop_q <= 1'b1;
					end
				end
				FE_IDLE, FE_TRACE: begin
					if (!flush && q_in_ready) begin
						if (tc_hit) begin
							fe_q <= FE_TRACE;
						end else begin
							fe_q <= FE_WAIT;
							fetch_req_q <= 1'b1;
							fetch_addr_q <= pc_q;
						end
					end
				end
				default: fe_q <= FE_IDLE;
			endcase
			if (flush)
				pc_q <= redir_pc;
			else if (fe_push)
				pc_q <= fe_next;
		end
	end

	// Trace cache valid bits; a mispredicted path loses its trace.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tc_v_q <= '0;
		end else begin
			if (fe_q == FE_WAIT && fe_push)
				tc_v_q[tc_idx] <= 1'b1;
			if (mis_d)
				tc_v_q[purge_pc[TB-1:0]] <= 1'b0;
		end
	end

	// Trace contents carry their own address as the tag.
	always_ff @(posedge clk_sys) begin
		if (fe_q == FE_WAIT && fe_push)
			tc_uop_q[tc_idx] <= fe_uop;
	end

	tcop_fifo #(
		.W($bits(tcop_uop_type)),
		.D(FIFO_DEPTH)
	) u_queue (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.flush(flush),
		.in_valid(fe_push),
		.in_ready(q_in_ready),
		.in_data(fe_uop),
		.out_valid(q_valid),
		.out_ready(q_pop),
		.out_data(q_uop)
	);

	// ****************************************************************
	// Out-of-order issue
	// ****************************************************************
	logic [ROB_DEPTH-1:0] issue_d;
	logic fp_take;
	int n_iss;
	int n_alu;
	logic [RB-1:0] e;

	assign q_pop = q_valid && cnt_q != (RB+1)'(ROB_DEPTH) && !flush;

	// Oldest-first scan; a waiting entry is skipped rather than blocking.
	always_comb begin
		issue_d = '0;
		fp_take = 1'b0;
		n_iss = 0;
		n_alu = 0;
		e = '0;
		for (int k = 0; k < ROB_DEPTH; k++) begin
			e = head_q + RB'(k);
			if (rob_v_q[e] && !rob_iss_q[e] && rob_wait_q[e] == 4'h0
					&& n_iss < MAX_DISPATCH) begin
				if (rob_uop_q[e].kind == KIND_FP) begin
					if (!fp_busy_q && !fp_take) begin
						issue_d[e] = 1'b1;
						fp_take = 1'b1;
						n_iss++;
					end
				end else if (rob_uop_q[e].kind != KIND_ALU || n_alu < ALU_PORTS) begin
					issue_d[e] = 1'b1;
					n_iss++;
					if (rob_uop_q[e].kind == KIND_ALU)
						n_alu++;
				end
			end
		end
	end

	// ****************************************************************
	// In-order retirement
	// ****************************************************************
	logic [ROB_DEPTH-1:0] ret_mask;
	logic [1:0] ret_n;
	logic stop;
	logic ret_store;
	logic exc_d;
	logic upd_v;
	logic [AW-1:0] st_addr_d;
	logic [AW-1:0] exc_pc_d;
	logic [AW-1:0] upd_pc;
	logic [AW-1:0] upd_tgt;
	logic [RB-1:0] r;

	// Stores and branches end the retire group, so each has its own cycle.
	always_comb begin
		ret_mask = '0;
		ret_n = 2'h0;
		stop = 1'b0;
		ret_store = 1'b0;
		exc_d = 1'b0;
		mis_d = 1'b0;
		upd_v = 1'b0;
		st_addr_d = '0;
		exc_pc_d = '0;
		upd_pc = '0;
		upd_tgt = '0;
		purge_pc = '0;
		r = '0;
		for (int k = 0; k < MAX_RETIRE; k++) begin
			r = head_q + RB'(k);
			if (!stop) begin
				if (!(rob_v_q[r] && rob_done_q[r])) begin
					stop = 1'b1;
				end else if (rob_uop_q[r].exc) begin
					exc_d = 1'b1;
					exc_pc_d = rob_uop_q[r].pc;
					stop = 1'b1;
				end else begin
					ret_mask[r] = 1'b1;
					ret_n = ret_n + 2'h1;
					if (rob_uop_q[r].kind == KIND_MEM && rob_uop_q[r].store) begin
						ret_store = 1'b1;
						st_addr_d = rob_uop_q[r].tgt;
						stop = 1'b1;
					end
					if (rob_uop_q[r].kind == KIND_BR) begin
						upd_v = 1'b1;
						upd_pc = rob_uop_q[r].pc;
						upd_tgt = rob_uop_q[r].tgt;
						stop = 1'b1;
						if (rob_uop_q[r].tgt != rob_uop_q[r].pred) begin
							mis_d = 1'b1;
							purge_pc = rob_uop_q[r].pred;
						end
					end
				end
			end
		end
	end

	assign flush = exc_d || mis_d;
	assign redir_pc = exc_d ? EXC_VECTOR : upd_tgt;
	assign upd_idx = upd_pc[BB-1:0];

	// Reorder buffer control; a flush empties everything younger.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rob_v_q <= '0;
			rob_iss_q <= '0;
			rob_done_q <= '0;
			head_q <= '0;
			tail_q <= '0;
			cnt_q <= '0;
			fp_busy_q <= 1'b0;
			for (int i = 0; i < ROB_DEPTH; i++)
				rob_wait_q[i] <= 4'h0;
		end else begin
			head_q <= head_q + RB'(ret_n);
			fp_busy_q <= fp_take;
			if (flush) begin
				tail_q <= head_q + RB'(ret_n);
				cnt_q <= '0;
			end else begin
				if (q_pop)
					tail_q <= tail_q + 1'b1;
				cnt_q <= cnt_q + (RB+1)'(q_pop) - (RB+1)'(ret_n);
			end
			for (int i = 0; i < ROB_DEPTH; i++) begin
				if (flush || ret_mask[i]) begin
					rob_v_q[i] <= 1'b0;
				end else if (q_pop && tail_q == RB'(i)) begin
					rob_v_q[i] <= 1'b1;
					rob_iss_q[i] <= 1'b0;
					rob_done_q[i] <= 1'b0;
					rob_wait_q[i] <= q_uop.lat;
				end else if (issue_d[i]) begin
					rob_iss_q[i] <= 1'b1;
					if (rob_uop_q[i].kind == KIND_FP)
						rob_wait_q[i] <= FP_LAT;
					else
						rob_done_q[i] <= 1'b1;
				end else if (rob_wait_q[i] != 4'h0) begin
					rob_wait_q[i] <= rob_wait_q[i] - 4'h1;
				end else if (rob_iss_q[i]) begin
					rob_done_q[i] <= 1'b1;
				end
			end
		end
	end

	// Uop payload needs no reset.
	always_ff @(posedge clk_sys) begin
		if (q_pop)
			rob_uop_q[tail_q] <= q_uop;
	end

	// Resolved branches refresh the predictor, which steers new paths.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			bpred_v_q <= '0;
		else if (upd_v)
			bpred_v_q[upd_idx] <= 1'b1;
	end

	// Predictor payload; the valid bit above guards its unreset contents.
	always_ff @(posedge clk_sys) begin
		if (upd_v) begin
			bpred_tag_q[upd_idx] <= upd_pc;
			bpred_tgt_q[upd_idx] <= upd_tgt;
		end
	end

	// ****************************************************************
	// Registered outputs
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			retire_count_q <= 2'h0;
			store_valid_q <= 1'b0;
			store_addr_q <= '0;
			exc_valid_q <= 1'b0;
			exc_pc_q <= '0;
			redirect_q <= 1'b0;
		end else begin
			retire_count_q <= ret_n;
			store_valid_q <= ret_store;
			if (ret_store)
				store_addr_q <= st_addr_d;
			exc_valid_q <= exc_d;
			if (exc_d)
				exc_pc_q <= exc_pc_d;
			redirect_q <= flush;
		end
	end

	assign fetch_req = fetch_req_q;
	assign fetch_addr = fetch_addr_q;
	assign trace_source = fe_q[2];
	assign retire_count = retire_count_q;
	assign store_valid = store_valid_q;
	assign store_addr = store_addr_q;
	assign exc_valid = exc_valid_q;
	assign exc_pc = exc_pc_q;
	assign redirect = redirect_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	property p_dispatch_max;
		$countones(issue_d) <= MAX_DISPATCH;
	endproperty
	a_dispatch_max: assert property (p_dispatch_max)
		else $error("More uops dispatched than allowed.");

	property p_fp_gap;
		fp_take |=> !fp_take;
	endproperty
	a_fp_gap: assert property (p_fp_gap)
		else $error("FP uops started back to back.");

	property p_retire_head;
		(ret_n != 2'h0) |-> rob_v_q[head_q] && rob_done_q[head_q];
	endproperty
	a_retire_head: assert property (p_retire_head)
		else $error("Retired past an unfinished oldest uop.");

	property p_store_out;
		ret_store |=> store_valid && store_addr == $past(st_addr_d);
	endproperty
	a_store_out: assert property (p_store_out)
		else $error("Retired store not committed next cycle.");

	property p_exc_restart;
		exc_d |=> exc_valid && redirect && pc_q == EXC_VECTOR && cnt_q == '0;
	endproperty
	a_exc_restart: assert property (p_exc_restart)
		else $error("Exception did not flush and restart.");

	property p_mis_redirect;
		(mis_d && !exc_d) |=> pc_q == $past(upd_tgt) && rob_v_q == '0;
	endproperty
	a_mis_redirect: assert property (p_mis_redirect)
		else $error("Mispredict did not flush and redirect.");

	property p_trace_src;
		(fe_q == FE_TRACE) |-> !fetch_req_q;
	endproperty
	a_trace_src: assert property (p_trace_src)
		else $error("Memory fetch while trace cache is the source.");

	property p_bpred_upd;
		upd_v |=> bpred_v_q[$past(upd_idx)] && bpred_tgt_q[$past(upd_idx)] == $past(upd_tgt);
	endproperty
	a_bpred_upd: assert property (p_bpred_upd)
		else $error("Branch buffer not updated after retire.");
endmodule : tcop_core

/* File: tb/tcop_mem_model.sv */
// Purpose: Behavioural instruction memory that answers the core's fetches.
// Assumes: One outstanding fetch; the bench fills prog_q before allowing answers.
// Notes: delay sets the answer latency, allow caps the answers since reset.
`timescale 1ns/1ns

// ********************************************************************
// Instruction memory model
// ********************************************************************
module tcop_mem_model (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic fetch_req,
	input wire logic [tcop_pkg::AW-1:0] fetch_addr,
	input wire logic [7:0] delay,
	input wire logic [7:0] allow,
	output logic mem_valid,
	output tcop_pkg::tcop_uop_type mem_uop
);
	import tcop_pkg::*;

	tcop_uop_type prog_q [512];
	logic [7:0] wait_q;
	logic [7:0] served_q;

	// One answer per request; the cycle of the answer is skipped so a standing request is
	// never answered twice. Idle data toggles so the core cannot rely on stale values.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mem_valid <= 1'b0;
			mem_uop <= '0;
			wait_q <= 8'h00;
			served_q <= 8'h00;
		end else begin
			mem_valid <= 1'b0;
			mem_uop <= ~mem_uop;
			if (fetch_req && !mem_valid && served_q < allow) begin
				if (wait_q >= delay) begin
					mem_valid <= 1'b1;
					mem_uop <= prog_q[fetch_addr[8:0]];
					wait_q <= 8'h00;
					served_q <= served_q + 8'h01;
				end else begin
					wait_q <= wait_q + 8'h01;
				end
			end
		end
	end
endmodule : tcop_mem_model

/* File: tb/tcop_tb_top.sv */
// Purpose: Self-checking bench for the trace-cache pipeline control.
// Assumes: The memory model is the only instruction source.
// Notes: Each scenario resets the core first, so scenarios do not leak state.
`timescale 1ns/1ns

module tcop_tb_top;
	import tcop_pkg::*;

	logic clk_sys;
	logic reset_n;
	logic [7:0] delay;
	logic [7:0] allow;
	logic mem_valid;
	tcop_uop_type mem_uop;
	logic fetch_req;
	logic [AW-1:0] fetch_addr;
	logic trace_source;
	logic [1:0] retire_count;
	logic store_valid;
	logic [AW-1:0] store_addr;
	logic exc_valid;
	logic [AW-1:0] exc_pc;
	logic redirect;
	int errors = 0;
	int compares = 0;
	int cyc, n_ret, n_store, n_exc, n_redir, n_rise, t_ans, t_ret, ret_at_exc, n_peak;
	logic [AW-1:0] exc_pc_s, fa_exc;
	logic fr_p, fa_exc_set;
	logic [AW-1:0] fa_q [$];
	logic [AW-1:0] st_q [$];

	// ****************************************************************
	// Clock, design and memory
	// ****************************************************************
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	tcop_core u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .mem_valid(mem_valid),
		.mem_uop(mem_uop), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
		.trace_source(trace_source), .retire_count(retire_count), .store_valid(store_valid),
		.store_addr(store_addr), .exc_valid(exc_valid), .exc_pc(exc_pc), .redirect(redirect));

	tcop_mem_model u_mem (.clk_sys(clk_sys), .reset_n(reset_n), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .delay(delay), .allow(allow), .mem_valid(mem_valid),
		.mem_uop(mem_uop));

	// ****************************************************************
	// Monitor
	// ****************************************************************
	// Outputs are sampled on the rising edge, before that edge's updates land.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			{cyc, n_ret, n_store, n_exc, n_redir, n_rise, t_ans, t_ret, ret_at_exc, n_peak} = '0;
			fr_p = 1'b0;
			fa_exc_set = 1'b0;
			fa_q.delete();
			st_q.delete();
		end else begin
			cyc++;
			if (mem_valid === 1'b1) begin
				t_ans = cyc;
				fa_q.push_back(fetch_addr);
			end
			if (retire_count !== 2'h0 && n_ret == 0)
				t_ret = cyc;
			n_ret += retire_count;
			if (retire_count > n_peak)
				n_peak = int'(retire_count);
			if (store_valid === 1'b1)
				st_q.push_back(store_addr);
			n_store = st_q.size();
			if (exc_valid === 1'b1) begin
				if (n_exc == 0) begin
					exc_pc_s = exc_pc;
					ret_at_exc = n_ret;
				end
				n_exc++;
			end
			if (redirect === 1'b1)
				n_redir++;
			if (fetch_req === 1'b1 && fr_p !== 1'b1) begin
				n_rise++;
				if (n_exc > 0 && !fa_exc_set) begin
					fa_exc = fetch_addr;
					fa_exc_set = 1'b1;
				end
			end
			fr_p = fetch_req;
		end
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	// A wait that ran out of its bound ends the run at once.
	task automatic tmo(input int i, input int lim);
		if (i >= lim) begin
			errors++;
			$display("Error at %0t ns: wait of %0d cycles ran out", $time, lim);
			summarize();
		end
	endtask : tmo

	function automatic tcop_uop_type mk(input logic [1:0] k, input logic [3:0] l,
		input logic s, input logic e, input logic [AW-1:0] t);
		mk = '{pc: 16'h0000, kind: k, lat: l, store: s, exc: e, tgt: t, pred: 16'h0000};
	endfunction : mk

	// Straight-line ALU code everywhere, then the core is reset for 8 cycles.
	task automatic reset_dut();
		for (int i = 0; i < 512; i++)
			u_mem.prog_q[i] = mk(KIND_ALU, 4'h0, 1'b0, 1'b0, 16'(i + 1));
		@(posedge clk_sys);
		reset_n <= 1'b0;
		allow <= 8'h00;
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
	endtask : reset_dut

	task automatic run(input logic [7:0] n, input logic [7:0] d);
		@(posedge clk_sys);
		allow <= n;
		delay <= d;
	endtask : run

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Twelve sequential fetches retire exactly once each, then nothing more retires.
	// A slow first uop lets younger ones finish, so they retire three at a time.
	task automatic s_order();
		int i;
		reset_dut();
		u_mem.prog_q[0] = mk(KIND_ALU, 4'hf, 1'b0, 1'b0, 16'h0001);
		run(8'd12, 8'd1);
		for (i = 0; i < 2000 && n_ret < 12; i++) @(negedge clk_sys);
		tmo(i, 2000);
		repeat (30) @(negedge clk_sys);
		chk(n_ret, 12);
		chk(n_peak, 3);
		for (int k = 0; k < 12; k++)
			chk(fa_q[k], k);
		chk(trace_source, 1'b0);
	endtask : s_order

	// Single uop latency from memory answer to retire count, per kind.
	task automatic s_latency();
		logic [1:0] kd [5];
		logic [3:0] lt [5];
		int ex [5];
		int i;
		kd = '{KIND_ALU, KIND_MEM, KIND_BR, KIND_FP, KIND_ALU};
		lt = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h3};
		ex = '{4, 4, 4, 6, 7};
		for (int k = 0; k < 5; k++) begin
			reset_dut();
			u_mem.prog_q[0] = mk(kd[k], lt[k], 1'b0, 1'b0, 16'h0001);
			run(8'd1, 8'd0);
			for (i = 0; i < 200 && n_ret < 1; i++) @(negedge clk_sys);
			tmo(i, 200);
			chk(t_ret - t_ans, ex[k]);
			chk(n_ret, 1);
		end
	endtask : s_latency

	// Stores commit in program order even when the oldest waits longest.
	task automatic s_store();
		int i;
		reset_dut();
		for (int k = 0; k < 4; k++)
			u_mem.prog_q[k] = mk(KIND_MEM, (k == 0) ? 4'h5 : 4'h0, 1'b1, 1'b0, 16'(16'h0040 + k));
		run(8'd4, 8'd2);
		for (i = 0; i < 600 && n_store < 4; i++) @(negedge clk_sys);
		tmo(i, 600);
		for (int k = 0; k < 4; k++)
			chk(st_q[k], 16'h0040 + k);
		chk(n_ret, 4);
	endtask : s_store

	// A fault at the third uop: older uops retire, the younger store never commits.
	task automatic s_exc();
		int i;
		reset_dut();
		u_mem.prog_q[2] = mk(KIND_ALU, 4'h0, 1'b0, 1'b1, 16'h0003);
		u_mem.prog_q[3] = mk(KIND_MEM, 4'h0, 1'b1, 1'b0, 16'h0077);
		run(8'd8, 8'd0);
		for (i = 0; i < 600 && n_exc < 1; i++) @(negedge clk_sys);
		tmo(i, 600);
		repeat (60) @(negedge clk_sys);
		chk(exc_pc_s, 16'h0002);
		chk(ret_at_exc, 2);
		chk(n_store, 0);
		chk(n_exc, 1);
		chk(fa_exc, EXC_VECTOR);
		chk(n_redir > 0, 1);
	endtask : s_exc

	// A backward branch mispredicts once, then the loop runs from the trace cache.
	task automatic s_loop();
		int i, r0, f0, d0;
		reset_dut();
		u_mem.prog_q[1] = mk(KIND_BR, 4'h0, 1'b0, 1'b0, 16'h0000);
		run(8'd20, 8'd1);
		for (i = 0; i < 1000 && trace_source !== 1'b1; i++) @(negedge clk_sys);
		tmo(i, 1000);
		chk(n_redir > 0, 1);
		r0 = n_ret;
		f0 = n_rise;
		d0 = n_redir;
		repeat (100) @(negedge clk_sys);
		chk(trace_source, 1'b1);
		chk(n_rise - f0, 0);
		chk(n_redir - d0, 0);
		chk(n_ret - r0 > 10, 1);
	endtask : s_loop

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		reset_n = 1'b0;
		delay = 8'h00;
		allow = 8'h00;
		s_order();
		s_latency();
		s_store();
		s_exc();
		s_loop();
		summarize();
	end
endmodule : tcop_tb_top
